// File: logic/dpc_cfg.svh
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH
// Register word addresses on the plain register port.
`define DPC_ADDR_ERR 8'h00
`define DPC_ADDR_STAT 8'h04
`define DPC_ADDR_CFG 8'h08
`define DPC_ADDR_LEN 8'h0C
`define DPC_ADDR_REL 8'h2C
`define DPC_ADDR_IRQ_STAT 8'h10
`define DPC_ADDR_IRQ_EN 8'h14
`define DPC_ADDR_IRQ_CLR 8'h18
// Error register bit positions.
`define DPC_ERR_SUM 0
`define DPC_ERR_FRAME 1
`define DPC_ERR_PROLOG 2
`define DPC_ERR_SUBFRAME 4
`define DPC_ERR_REL 7
`define DPC_ERR_SNR 8
`define DPC_ERR_PERM 9
// Status register field positions.
`define DPC_ST_BUSY 1
`define DPC_ST_ERR 2
`define DPC_ST_WAIT_LO 3
`define DPC_ST_HALT 10
`define DPC_ST_MAP 11
`define DPC_ST_SUB_LO 12
`define DPC_ST_ITER_LO 16
`define DPC_ST_SNR_LO 21
`define DPC_ST_CRC 23
`define DPC_ST_TOP_LO 24
// Parameter limits.
`define DPC_SNR_MAX 16'd100
`define DPC_REL_MIN 16'd40
`define DPC_REL_SP12 16'd128
`define DPC_REL_SP3_MIN 16'd65
`define DPC_SUBF_MAX 16'd5114
`define DPC_PRO_MIN 16'd4
`define DPC_PRO_MAX 16'd48
`define DPC_FSA_MIN 16'd40
`define DPC_FSA_MAX 16'd20730
`define DPC_FSP12_MIN 16'd256
`define DPC_FSP_MAX 16'd20480
`define DPC_FSP3_MIN 16'd128
// Reset values.
`define DPC_STAT_RST 32'h0000_0000
`endif

// File: logic/dpc_pkg.sv
package dpc_pkg;
	typedef logic [15:0] dpc_len_t;
	typedef logic [1:0] dpc_variant_t;
endpackage

// File: logic/dpc_chk_if.sv
`timescale 1ns/1ps
// Parameters in, error bits out, between top and checker.
interface dpc_chk_if;
	import dpc_pkg::*;
	logic shared_mode;
	dpc_variant_t variant;
	logic perm_load;
	dpc_len_t frame_len;
	dpc_len_t subframe_len;
	dpc_len_t prolog_len;
	dpc_len_t rel_len;
	dpc_len_t rel_win;
	dpc_len_t snr_thr;
	logic [9:0] err;
	modport top(output shared_mode, variant, perm_load, frame_len, subframe_len, prolog_len,
		rel_len, rel_win, snr_thr, input err);
	modport chk(input shared_mode, variant, perm_load, frame_len, subframe_len, prolog_len,
		rel_len, rel_win, snr_thr, output err);
endinterface

// File: logic/dpc_param_chk.sv
`timescale 1ns/1ps
`include "dpc_cfg.svh"
// Combinational parameter checker.
module dpc_param_chk
	import dpc_pkg::*;
(
	// Parameters and result.
	dpc_chk_if.chk c
);
	logic sp12;
	logic sp3;
	assign sp12 = c.shared_mode && (c.variant == 2'd1 || c.variant == 2'd2);
	assign sp3 = c.shared_mode && (c.variant == 2'd3);
	// Per-field checks; summary is the OR of all of them.
	always_comb begin
		c.err = '0;
		c.err[`DPC_ERR_PERM] = c.shared_mode && c.perm_load;
		c.err[`DPC_ERR_SNR] = c.snr_thr > `DPC_SNR_MAX;
		c.err[`DPC_ERR_REL] = (c.rel_len < `DPC_REL_MIN) || (sp12 && c.rel_win != `DPC_REL_SP12)
			|| (sp3 && c.rel_win < `DPC_REL_SP3_MIN);
		c.err[`DPC_ERR_SUBFRAME] = c.subframe_len > `DPC_SUBF_MAX;
		c.err[`DPC_ERR_PROLOG] = c.prolog_len < `DPC_PRO_MIN || c.prolog_len > `DPC_PRO_MAX;
		if (!c.shared_mode) begin
			c.err[`DPC_ERR_FRAME] = c.frame_len < `DPC_FSA_MIN || c.frame_len > `DPC_FSA_MAX;
		end else if (sp3) begin
			c.err[`DPC_ERR_FRAME] = c.frame_len < `DPC_FSP3_MIN || c.frame_len > `DPC_FSP_MAX;
		end else if (sp12) begin
			c.err[`DPC_ERR_FRAME] = c.frame_len < `DPC_FSP12_MIN || c.frame_len > `DPC_FSP_MAX
				|| c.frame_len[7:0] != 8'h00;
		end else begin
			c.err[`DPC_ERR_FRAME] = 1'b0;
		end
		c.err[`DPC_ERR_SUM] = |c.err[9:1];
	end
endmodule

// File: logic/dpc_regs.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dpc_cfg.svh"
// Contract
// - Shared mode with permutation-load flag set raises error bit 9.
// - Error bit 7 set when reliability length below 40.
// - Shared mode variant 1 or 2: bit 7 when window differs from 128.
// - Shared mode variant 3: bit 7 when window below 65.
// - Error bit 4 set when subframe length exceeds 5114.
// - Error bit 2 set when prolog below 4 or above 48.
// - Standalone: bit 1 when frame below 40 or above 20730.
// - Shared variant 1/2: bit 1 when frame outside 256..20480 or not multiple of 256.
// - Shared variant 3: bit 1 when frame below 128 or above 20480.
// - Error bit 0 set whenever any parameter error exists.
// - Error bits 6-5 and 3 read zero, writes ignored.
// - Status word read-only, reset zero, fixed field layout.
// - Any parameter error raises the host interrupt when its enable bit is set.
// - Status bits 9..3 show the seven buffer-wait flags.
// - Status bit 1 is high when MAP state nonzero.
module dpc_regs
	import dpc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Decoder state inputs.
	input wire logic [3:0] top_fsm_state_i,
	input wire logic crc_pass_i,
	input wire logic [1:0] map_quality_result_i,
	input wire logic [4:0] iter_i,
	input wire logic [3:0] substate_i,
	input wire logic map_active_i,
	input wire logic debug_halted_i,
	input wire logic [3:0] map_state_i,
	input wire logic awaiting_outparam_read_i,
	input wire logic awaiting_decision_read_i,
	input wire logic awaiting_extrinsic_read_i,
	input wire logic awaiting_apriori_write_i,
	input wire logic awaiting_symbol_write_i,
	input wire logic awaiting_permutation_write_i,
	input wire logic awaiting_config_write_i,
	// Interrupt.
	output logic irq_o
);
	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic shared_processing_mode_q;
	dpc_variant_t variant_q;
	logic perm_load_q;
	dpc_len_t prolog_q;
	dpc_len_t snr_q;
	dpc_len_t frame_q;
	dpc_len_t subframe_q;
	dpc_len_t rel_q;
	dpc_len_t reliability_window_len_q;
	logic [31:0] decoder_error_flags_q;
	logic [31:0] decoder_status_q;
	logic [9:0] irq_stat_q;
	logic [9:0] irq_en_q;
	logic [9:0] err_new;
	logic [9:0] err_rise;

	dpc_chk_if chk_bus ();

	// Software writes the parameter words.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			shared_processing_mode_q <= 1'b0;
			variant_q <= 2'd0;
			perm_load_q <= 1'b0;
			prolog_q <= 16'h0000;
			snr_q <= 16'h0000;
			frame_q <= 16'h0000;
			subframe_q <= 16'h0000;
			rel_q <= 16'h0000;
			reliability_window_len_q <= 16'h0000;
		end else if (wr_i) begin
			if (addr_i == `DPC_ADDR_CFG) begin
				shared_processing_mode_q <= wdata_i[0];
				variant_q <= wdata_i[2:1];
				perm_load_q <= wdata_i[3];
				prolog_q <= {10'h000, wdata_i[9:4]};
				snr_q <= wdata_i[31:16];
			end else if (addr_i == `DPC_ADDR_LEN) begin
				frame_q <= wdata_i[15:0];
				subframe_q <= wdata_i[31:16];
			end else if (addr_i == `DPC_ADDR_REL) begin
				rel_q <= wdata_i[15:0];
				reliability_window_len_q <= wdata_i[31:16];
			end
		end
	end

	// ---------------------------------------------------------------
	// Checker hookup
	// ---------------------------------------------------------------
	assign chk_bus.shared_mode = shared_processing_mode_q;
	assign chk_bus.variant = variant_q;
	assign chk_bus.perm_load = perm_load_q;
	assign chk_bus.frame_len = frame_q;
	assign chk_bus.subframe_len = subframe_q;
	assign chk_bus.prolog_len = prolog_q;
	assign chk_bus.rel_len = rel_q;
	assign chk_bus.rel_win = reliability_window_len_q;
	assign chk_bus.snr_thr = snr_q;
	assign err_new = chk_bus.err;

	dpc_param_chk u_chk (
		.c(chk_bus.chk)
	);

	// Registered error word; reserved bits forced to zero.
	// reserved bits zero
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			decoder_error_flags_q <= 32'h0000_0000;
		end else begin
			decoder_error_flags_q <= {22'h00_0000, err_new[9:7], 2'b00, err_new[4], 1'b0,
				err_new[2:0]};
		end
	end

	// ---------------------------------------------------------------
	// Status word
	// ---------------------------------------------------------------
	// status capture
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			decoder_status_q <= `DPC_STAT_RST;
		end else begin
			decoder_status_q <= {4'h0, top_fsm_state_i, crc_pass_i, map_quality_result_i,
				iter_i, substate_i, map_active_i, debug_halted_i,
				awaiting_outparam_read_i, awaiting_decision_read_i,
				awaiting_extrinsic_read_i, awaiting_apriori_write_i,
				awaiting_symbol_write_i, awaiting_permutation_write_i,
				awaiting_config_write_i, decoder_error_flags_q[`DPC_ERR_SUM],
				map_state_i != 4'h0, 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	assign err_rise = decoder_error_flags_q[9:0] & ~irq_stat_q;

	// Sticky event bits; a new error wins over a clear in the same cycle.
	// error interrupt
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_stat_q <= 10'h000;
		end else begin
			if (wr_i && addr_i == `DPC_ADDR_IRQ_CLR) begin
				irq_stat_q <= (irq_stat_q & ~wdata_i[9:0]) | decoder_error_flags_q[9:0];
			end else begin
				irq_stat_q <= irq_stat_q | err_rise;
			end
		end
	end

	// Enable register.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_en_q <= 10'h000;
		end else if (wr_i && addr_i == `DPC_ADDR_IRQ_EN) begin
			irq_en_q <= wdata_i[9:0];
		end
	end

	assign irq_o = |(irq_stat_q & irq_en_q);

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// Read data stand one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			unique case (addr_i)
				`DPC_ADDR_ERR: rdata_o <= decoder_error_flags_q;
				`DPC_ADDR_STAT: rdata_o <= decoder_status_q;
				`DPC_ADDR_CFG: rdata_o <= {snr_q, 6'h00, prolog_q[5:0], perm_load_q,
					variant_q, shared_processing_mode_q};
				`DPC_ADDR_LEN: rdata_o <= {subframe_q, frame_q};
				`DPC_ADDR_REL: rdata_o <= {reliability_window_len_q, rel_q};
				`DPC_ADDR_IRQ_STAT: rdata_o <= {22'h00_0000, irq_stat_q};
				`DPC_ADDR_IRQ_EN: rdata_o <= {22'h00_0000, irq_en_q};
				default: rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_perm;
		@(posedge mclk_i) disable iff (rst_i)
		(shared_processing_mode_q && perm_load_q) |=> decoder_error_flags_q[`DPC_ERR_PERM];
	endproperty
	a_perm: assert property (p_perm) else $error("perm load error missing");

	property p_snr;
		@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> decoder_error_flags_q[`DPC_ERR_SNR] == ($past(snr_q) > `DPC_SNR_MAX);
	endproperty
	a_snr: assert property (p_snr) else $error("snr error wrong");

	property p_rel;
		@(posedge mclk_i) disable iff (rst_i)
		(rel_q < `DPC_REL_MIN) |=> decoder_error_flags_q[`DPC_ERR_REL];
	endproperty
	a_rel: assert property (p_rel) else $error("reliability error missing");

	property p_subf;
		@(posedge mclk_i) disable iff (rst_i)
		(subframe_q > `DPC_SUBF_MAX) |=> decoder_error_flags_q[`DPC_ERR_SUBFRAME];
	endproperty
	a_subf: assert property (p_subf) else $error("subframe error missing");

	property p_pro;
		@(posedge mclk_i) disable iff (rst_i)
		(prolog_q >= `DPC_PRO_MIN && prolog_q <= `DPC_PRO_MAX)
			|=> !decoder_error_flags_q[`DPC_ERR_PROLOG];
	endproperty
	a_pro: assert property (p_pro) else $error("prolog error spurious");

	property p_fsa;
		@(posedge mclk_i) disable iff (rst_i)
		(!shared_processing_mode_q && frame_q > `DPC_FSA_MAX)
			|=> decoder_error_flags_q[`DPC_ERR_FRAME];
	endproperty
	a_fsa: assert property (p_fsa) else $error("frame error missing");

	property p_sum;
		@(posedge mclk_i) disable iff (rst_i)
		decoder_error_flags_q[`DPC_ERR_SUM] == (|decoder_error_flags_q[9:1]);
	endproperty
	a_sum: assert property (p_sum) else $error("summary bit wrong");

	property p_resv;
		@(posedge mclk_i) disable iff (rst_i)
		decoder_error_flags_q[6:5] == 2'b00 && !decoder_error_flags_q[3];
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");

	property p_sterr;
		@(posedge mclk_i) disable iff (rst_i)
		decoder_error_flags_q[`DPC_ERR_SUM] |=> decoder_status_q[`DPC_ST_ERR];
	endproperty
	a_sterr: assert property (p_sterr) else $error("status error bit lags");

	sequence s_err_new;
		decoder_error_flags_q[`DPC_ERR_SUM] && irq_en_q[`DPC_ERR_SUM]
			&& !(wr_i && addr_i == `DPC_ADDR_IRQ_EN);
	endsequence
	property p_irq;
		@(posedge mclk_i) disable iff (rst_i)
		s_err_new |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	property p_busy;
		@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> decoder_status_q[`DPC_ST_BUSY] == ($past(map_state_i) != 4'h0);
	endproperty
	a_busy: assert property (p_busy) else $error("busy bit wrong");

	property p_rel_sp12;
		@(posedge mclk_i) disable iff (rst_i)
		(shared_processing_mode_q && (variant_q == 2'd1 || variant_q == 2'd2)
			&& reliability_window_len_q != `DPC_REL_SP12)
			|=> decoder_error_flags_q[`DPC_ERR_REL];
	endproperty
	a_rel_sp12: assert property (p_rel_sp12) else $error("window error missing");

	property p_rel_sp3;
		@(posedge mclk_i) disable iff (rst_i)
		(shared_processing_mode_q && variant_q == 2'd3
			&& reliability_window_len_q < `DPC_REL_SP3_MIN)
			|=> decoder_error_flags_q[`DPC_ERR_REL];
	endproperty
	a_rel_sp3: assert property (p_rel_sp3) else $error("short window error missing");

	property p_fsp12;
		@(posedge mclk_i) disable iff (rst_i)
		(shared_processing_mode_q && (variant_q == 2'd1 || variant_q == 2'd2)
			&& (frame_q < `DPC_FSP12_MIN || frame_q > `DPC_FSP_MAX))
			|=> decoder_error_flags_q[`DPC_ERR_FRAME];
	endproperty
	a_fsp12: assert property (p_fsp12) else $error("shared frame error missing");

	property p_fsp3;
		@(posedge mclk_i) disable iff (rst_i)
		(shared_processing_mode_q && variant_q == 2'd3
			&& (frame_q < `DPC_FSP3_MIN || frame_q > `DPC_FSP_MAX))
			|=> decoder_error_flags_q[`DPC_ERR_FRAME];
	endproperty
	a_fsp3: assert property (p_fsp3) else $error("variant 3 frame error missing");

	property p_st_resv;
		@(posedge mclk_i) disable iff (rst_i)
		decoder_status_q[31:28] == 4'h0 && !decoder_status_q[0];
	endproperty
	a_st_resv: assert property (p_st_resv) else $error("status reserved bits set");

	// Buffer-wait inputs in status bit order, for the wait-flag check.
	logic [6:0] wait_flags;
	assign wait_flags = {awaiting_outparam_read_i, awaiting_decision_read_i,
		awaiting_extrinsic_read_i, awaiting_apriori_write_i, awaiting_symbol_write_i,
		awaiting_permutation_write_i, awaiting_config_write_i};

	property p_wait;
		@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> decoder_status_q[9:`DPC_ST_WAIT_LO] == $past(wait_flags);
	endproperty
	a_wait: assert property (p_wait) else $error("wait flags wrong");

	property p_crc;
		@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> decoder_status_q[`DPC_ST_CRC] == $past(crc_pass_i)
			&& decoder_status_q[`DPC_ST_SNR_LO +: 2] == $past(map_quality_result_i);
	endproperty
	a_crc: assert property (p_crc) else $error("crc or snr status wrong");
endmodule

// File: testbench/test_decoder_param_check_status.sv
`timescale 1ns/1ps
`include "dpc_cfg.svh"
module test_decoder_param_check_status;
	// Design port signals.
	logic mclk_i, rst_i, wr_i, rd_i, irq_o;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [3:0] top_i, sub_i, mst_i;
	logic crc_i, act_i, halt_i;
	logic [1:0] q_i;
	logic [4:0] it_i;
	logic [6:0] wait_i;
	int err_count, checked;
	logic [31:0] seed;
	// Boundary bases for the frame length draw.
	logic [15:0] fb[6] = '{16'd40, 16'd20730, 16'd256, 16'd20480, 16'd128, 16'd1024};

	dpc_regs dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .top_fsm_state_i(top_i),
		.crc_pass_i(crc_i), .map_quality_result_i(q_i), .iter_i(it_i), .substate_i(sub_i),
		.map_active_i(act_i), .debug_halted_i(halt_i), .map_state_i(mst_i),
		.awaiting_outparam_read_i(wait_i[6]), .awaiting_decision_read_i(wait_i[5]),
		.awaiting_extrinsic_read_i(wait_i[4]), .awaiting_apriori_write_i(wait_i[3]),
		.awaiting_symbol_write_i(wait_i[2]), .awaiting_permutation_write_i(wait_i[1]),
		.awaiting_config_write_i(wait_i[0]), .irq_o(irq_o));

	// Free running clock at 8 ns.
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// Xorshift source, so every run draws the same values.
	function logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Mostly a value one below, at or above a limit, sometimes anything.
	function automatic logic [15:0] near(logic [15:0] b, logic [31:0] r);
		return (r[5:4] == 2'd0) ? r[31:16] : b + 16'(r[9:8] % 3) - 16'h0001;
	endfunction

	// Expected error word from the programmed parameters.
	function automatic logic [31:0] exp_err(logic sm, logic [1:0] v, logic pl, logic [5:0] pro,
		logic [15:0] snr, logic [15:0] f, logic [15:0] sf, logic [15:0] rl, logic [15:0] rw);
		logic [31:0] e;
		e = 32'h0000_0000;
		e[9] = sm & pl;
		e[8] = snr > 16'd100;
		e[7] = (rl < 16'd40) || (sm && (v == 2'd1 || v == 2'd2) && rw != 16'd128) ||
			(sm && v == 2'd3 && rw < 16'd65);
		e[4] = sf > 16'd5114;
		e[2] = (pro < 6'd4) || (pro > 6'd48);
		if (!sm) begin
			e[1] = (f < 16'd40) || (f > 16'd20730);
		end else if (v == 2'd1 || v == 2'd2) begin
			e[1] = (f < 16'd256) || (f > 16'd20480) || (f[7:0] != 8'h00);
		end else if (v == 2'd3) begin
			e[1] = (f < 16'd128) || (f > 16'd20480);
		end
		e[0] = |e[9:1];
		return e;
	endfunction

	// Compare one value and count it.
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle register write.
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	// One-cycle register read, data checked in the following cycle.
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask

	// Verdict and end of run.
	task automatic conclude();
		if (err_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence: corner cases, then a random sweep over all modes.
	initial begin
		logic [31:0] r, e, en;
		logic [15:0] f, sf, snr, rl, rw;
		logic [5:0] pro;
		logic pl;
		err_count = 0;
		checked = 0;
		seed = 32'h78d2_15ef;
		rst_i = 1'b1;
		{wr_i, rd_i, addr_i, wdata_i} = '0;
		{top_i, crc_i, q_i, it_i, sub_i, act_i, halt_i, wait_i, mst_i} = '0;
		@(posedge mclk_i);
		#1 chk(rdata_o, 32'h0000_0000);
		chk({31'h0, irq_o}, 32'h0000_0000);
		@(posedge mclk_i);
		rst_i <= 1'b0;
		wr(`DPC_ADDR_IRQ_EN, 32'hffff_ffff);
		wr(`DPC_ADDR_ERR, 32'hffff_ffff);
		wr(`DPC_ADDR_STAT, 32'hffff_ffff);
		repeat (5) @(posedge mclk_i);
		rd(`DPC_ADDR_ERR, 32'h0000_0087);
		rd(`DPC_ADDR_STAT, 32'h0000_0004);
		rd(8'hfc, 32'h0000_0000);
		rd(`DPC_ADDR_IRQ_STAT, 32'h0000_0087);
		chk({31'h0, irq_o}, 32'h0000_0001);
		// A clean setup keeps old events sticky until cleared.
		wr(`DPC_ADDR_CFG, {16'd50, 6'h00, 6'd24, 4'h0});
		wr(`DPC_ADDR_LEN, {16'd100, 16'd1000});
		wr(`DPC_ADDR_REL, {16'd0, 16'd64});
		repeat (5) @(posedge mclk_i);
		rd(`DPC_ADDR_ERR, 32'h0000_0000);
		rd(`DPC_ADDR_IRQ_STAT, 32'h0000_0087);
		wr(`DPC_ADDR_IRQ_CLR, 32'hffff_ffff);
		repeat (4) @(posedge mclk_i);
		rd(`DPC_ADDR_IRQ_STAT, 32'h0000_0000);
		chk({31'h0, irq_o}, 32'h0000_0000);
		for (int i = 0; i < 64; i++) begin
			r = nxt();
			f = near(fb[r[14:12] % 6], r);
			sf = near(16'd5114, nxt());
			snr = near(16'd100, nxt());
			rl = near(16'd40, nxt());
			r = nxt();
			rw = near(r[11] ? 16'd128 : 16'd65, r);
			r = nxt();
			pro = 6'(near(r[12] ? 16'd4 : 16'd48, r));
			pl = r[13];
			en = nxt();
			r = nxt();
			@(posedge mclk_i);
			{top_i, crc_i, q_i, it_i, sub_i, act_i, halt_i, wait_i, mst_i} <= r[28:0];
			wr(`DPC_ADDR_CFG, {snr, 6'h00, pro, pl, i[2:1], i[0]});
			wr(`DPC_ADDR_LEN, {sf, f});
			wr(`DPC_ADDR_REL, {rw, rl});
			wr(`DPC_ADDR_IRQ_EN, en);
			repeat (5) @(posedge mclk_i);
			e = exp_err(i[0], i[2:1], pl, pro, snr, f, sf, rl, rw);
			rd(`DPC_ADDR_ERR, e);
			rd(`DPC_ADDR_STAT, {4'h0, r[28:4], e[0], |r[3:0], 1'b0});
			rd(`DPC_ADDR_CFG, {snr, 6'h00, pro, pl, i[2:1], i[0]});
			rd(`DPC_ADDR_LEN, {sf, f});
			rd(`DPC_ADDR_REL, {rw, rl});
			rd(`DPC_ADDR_IRQ_EN, {22'h00_0000, en[9:0]});
			wr(`DPC_ADDR_IRQ_CLR, 32'hffff_ffff);
			repeat (4) @(posedge mclk_i);
			rd(`DPC_ADDR_IRQ_STAT, e);
			chk({31'h0, irq_o}, {31'h0, |(e[9:0] & en[9:0])});
		end
		conclude();
	end
endmodule
